// ### spps_pkg.sv
// Purpose: Shared constants and carrier types for the six-pin port with pin steering.
// Assumes: AXI4-Lite register access with 32-bit data, one register per aligned word.
// Notes:   Byte offsets and reset values live here and nowhere else.
`default_nettype none
package spps_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_STEER = 8'h00;
	localparam logic [7:0] ADDR_LEVELS = 8'h04;
	localparam logic [7:0] ADDR_DIR = 8'h08;
	localparam logic [7:0] ADDR_LATCH = 8'h0C;
	localparam logic [7:0] ADDR_ANALOG = 8'h10;
	localparam logic [7:0] ADDR_OPEN_DRAIN = 8'h14;
	localparam logic [7:0] ADDR_SLEW = 8'h18;
	localparam logic [7:0] ADDR_THRESH = 8'h1C;

	// ----------------------------------------------------------------
	// Field positions and masks
	// ----------------------------------------------------------------
	localparam int BIT_RECEIVE = 7;
	localparam int BIT_WAVE_A = 6;
	localparam int BIT_WAVE_B = 5;
	localparam int BIT_TIMER_GATE = 3;
	localparam int BIT_TRANSMIT = 2;
	localparam int BIT_SECOND_PWM = 1;
	localparam int BIT_FIRST_PWM = 0;
	localparam logic [7:0] MASK_STEER = 8'hEF;
	localparam logic [7:0] MASK_PORT = 8'h37;
	localparam logic [7:0] MASK_THRESH = 8'h3F;
	localparam logic [7:0] MASK_ANALOG = 8'h17;
	localparam logic [7:0] DIR_PIN3_ONE = 8'h08;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_STEER = 8'h00;
	localparam logic [7:0] RST_DIR = 8'h37;
	localparam logic [7:0] RST_LATCH = 8'h00;
	localparam logic [7:0] RST_ANALOG = 8'h17;
	localparam logic [7:0] RST_OPEN_DRAIN = 8'h00;
	localparam logic [7:0] RST_SLEW = 8'h37;
	localparam logic [7:0] RST_THRESH = 8'h00;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic programming_data_en;
		logic programming_data;
		logic dac_output_en;
		logic clock_output_en;
		logic clock_output_pin;
		logic waveform_out_a_en;
		logic waveform_out_a;
		logic waveform_out_b_en;
		logic waveform_out_b;
		logic waveform_fault_en;
		logic waveform_fault;
		logic comparator_output_en;
		logic comparator_output;
		logic transmit_en;
		logic transmit;
		logic first_pwm_output_en;
		logic first_pwm_output;
		logic second_pwm_output_en;
		logic second_pwm_output;
		logic third_pwm_output_en;
		logic third_pwm_output;
	} spps_periph_s;

	typedef struct packed {
		logic [5:0] drive;
		logic [5:0] drive_en;
		logic [5:0] open_drain;
		logic [5:0] slew_limit;
		logic [5:0] schmitt;
	} spps_pad_s;

	typedef struct packed {
		logic serial_receive_or_sync_data;
		logic timer_gate_input;
		logic [5:0] analog_active;
	} spps_inputs_s;

endpackage
`default_nettype wire

// ### spps_port.sv
// Purpose: Six-pin port with direction, latch, analog, open-drain, slew, threshold and pin steering.
// Assumes: Pin levels and peripheral signals are synchronous to clk; AXI4-Lite slave with 32-bit data.
// Notes:   Pad outputs are registered, so pins follow the register state one cycle later.
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`default_nettype none
module spps_port
	import spps_pkg::*;
(
	input  wire logic                   clk,
	input  wire logic                   reset,
	input  wire logic [7:0]             s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output var  logic                   s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output var  logic                   s_axi_wready,
	output var  logic [1:0]             s_axi_bresp,
	output var  logic                   s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [7:0]             s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output var  logic                   s_axi_arready,
	output var  logic [31:0]            s_axi_rdata,
	output var  logic [1:0]             s_axi_rresp,
	output var  logic                   s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	input  wire logic [5:0]             pin_in,
	input  wire logic [5:0]             pin_schmitt_in,
	input  wire spps_pkg::spps_periph_s periph,
	output var  spps_pkg::spps_pad_s    pad,
	output var  spps_pkg::spps_inputs_s inputs
);

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [7:0]  steer_q;
	logic [7:0]  dir_q;
	logic [7:0]  latch_q;
	logic [7:0]  analog_q;
	logic [7:0]  open_drain_q;
	logic [7:0]  slew_q;
	logic [7:0]  thresh_q;
	logic [7:0]  aw_addr_q;
	logic        aw_have_q;
	logic [31:0] w_data_q;
	logic        w_have_q;
	logic        do_write;
	logic        write_ok;
	logic [7:0]  wbyte;
	logic [5:0]  digital_in;
	logic [7:0]  read_mux;
	logic        read_ok;
	logic [5:0]  drive_d;
	logic [5:0]  drive_en_d;

	function automatic logic known_addr(input logic [7:0] a);
		known_addr = (a == ADDR_STEER) || (a == ADDR_LEVELS) || (a == ADDR_DIR) || (a == ADDR_LATCH) ||
			(a == ADDR_ANALOG) || (a == ADDR_OPEN_DRAIN) || (a == ADDR_SLEW) || (a == ADDR_THRESH);
	endfunction

	// Picks the first enabled source of a priority chain, falling back to the latch.
	function automatic logic [1:0] pick(input logic [4:0] en, input logic [4:0] val, input logic lat,
		input logic gp_en);
		logic [1:0] r;
		r = {gp_en, lat};
		for (int i = 4; i >= 0; i--) begin
			if (en[i]) begin
				r = {1'b1, val[i]};
				break;
			end
		end
		pick = r;
	endfunction

	// ----------------------------------------------------------------
	// Write channel
	// ----------------------------------------------------------------
	assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
	assign write_ok = known_addr(aw_addr_q);
	assign wbyte = w_data_q[7:0];

	always_ff @(posedge clk) begin
		if (reset) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
			s_axi_awready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (do_write) begin
				aw_have_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			w_have_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				w_data_q <= {s_axi_wdata[31:8], s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00};
			end else if (do_write) begin
				w_have_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= write_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Control registers
	// ----------------------------------------------------------------
	// Byte lane 0 only; a write with strobe 0 clear leaves the register alone.
	logic strobe0_q;
	always_ff @(posedge clk) begin
		if (reset) begin
			strobe0_q <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			strobe0_q <= s_axi_wstrb[0];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			steer_q <= RST_STEER;
			dir_q <= RST_DIR;
			analog_q <= RST_ANALOG;
			open_drain_q <= RST_OPEN_DRAIN;
			slew_q <= RST_SLEW;
			thresh_q <= RST_THRESH;
		end else if (do_write && strobe0_q) begin
			case (aw_addr_q)
				ADDR_STEER: begin
					steer_q <= wbyte & MASK_STEER;
				end
				ADDR_DIR: begin
					dir_q <= wbyte & MASK_PORT;
				end
				ADDR_ANALOG: begin
					analog_q <= wbyte & MASK_ANALOG;
				end
				ADDR_OPEN_DRAIN: begin
					open_drain_q <= wbyte & MASK_PORT;
				end
				ADDR_SLEW: begin
					slew_q <= wbyte & MASK_PORT;
				end
				ADDR_THRESH: begin
					thresh_q <= wbyte & MASK_THRESH;
				end
				default: begin
				end
			endcase
		end
	end

	// Port and latch writes both land in the output latch.
	always_ff @(posedge clk) begin
		if (reset) begin
			latch_q <= RST_LATCH;
		end else if (do_write && strobe0_q && (aw_addr_q == ADDR_LEVELS || aw_addr_q == ADDR_LATCH)) begin
			latch_q <= wbyte & MASK_PORT;
		end
	end

	// ----------------------------------------------------------------
	// Input path
	// ----------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			digital_in[i] = (thresh_q[i] ? pin_schmitt_in[i] : pin_in[i]);
		end
		digital_in = digital_in & ~analog_q[5:0];
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			inputs <= '0;
		end else begin
			inputs.serial_receive_or_sync_data <= steer_q[BIT_RECEIVE] ? digital_in[5] : digital_in[1];
			inputs.timer_gate_input <= steer_q[BIT_TIMER_GATE] ? digital_in[3] : digital_in[4];
			inputs.analog_active <= analog_q[5:0];
		end
	end

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	always_comb begin
		read_ok = 1'b1;
		case (s_axi_araddr)
			ADDR_STEER: read_mux = steer_q;
			ADDR_LEVELS: read_mux = {2'b00, digital_in};
			ADDR_DIR: read_mux = dir_q | DIR_PIN3_ONE;
			ADDR_LATCH: read_mux = latch_q;
			ADDR_ANALOG: read_mux = analog_q;
			ADDR_OPEN_DRAIN: read_mux = open_drain_q;
			ADDR_SLEW: read_mux = slew_q;
			ADDR_THRESH: read_mux = thresh_q;
			default: begin
				read_mux = 8'h00;
				read_ok = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h00_0000, read_mux};
				s_axi_rresp <= read_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Output priority and steering
	// ----------------------------------------------------------------
	// Direction clear enables the latch driver; peripherals override it when enabled.
	always_comb begin
		logic [5:0] gp_en;
		logic [1:0] r;
		gp_en = ~dir_q[5:0];
		r = 2'b00;
		drive_d = 6'h00;
		drive_en_d = 6'h00;
		// Pin 0: programming data, wave B, DAC, transmit, second PWM, latch.
		r = pick({periph.programming_data_en,
			periph.waveform_out_b_en && !steer_q[BIT_WAVE_B],
			periph.dac_output_en,
			periph.transmit_en && !steer_q[BIT_TRANSMIT],
			periph.second_pwm_output_en && !steer_q[BIT_SECOND_PWM]},
			{periph.programming_data, periph.waveform_out_b, 1'b0, periph.transmit,
			periph.second_pwm_output}, latch_q[0], gp_en[0]);
		{drive_en_d[0], drive_d[0]} = r;
		// Pin 1: first PWM, latch.
		r = pick({4'h0, periph.first_pwm_output_en && !steer_q[BIT_FIRST_PWM]},
			{4'h0, periph.first_pwm_output}, latch_q[1], gp_en[1]);
		{drive_en_d[1], drive_d[1]} = r;
		// Pin 2: wave A, fault, comparator, third PWM, latch.
		r = pick({1'b0, periph.waveform_out_a_en && !steer_q[BIT_WAVE_A],
			periph.waveform_fault_en, periph.comparator_output_en, periph.third_pwm_output_en},
			{1'b0, periph.waveform_out_a, periph.waveform_fault, periph.comparator_output,
			periph.third_pwm_output}, latch_q[2], gp_en[2]);
		{drive_en_d[2], drive_d[2]} = r;
		// Pin 4: clock output, wave B, transmit, second PWM, latch.
		r = pick({1'b0, periph.clock_output_en,
			periph.waveform_out_b_en && steer_q[BIT_WAVE_B],
			periph.transmit_en && steer_q[BIT_TRANSMIT],
			periph.second_pwm_output_en && steer_q[BIT_SECOND_PWM]},
			{1'b0, periph.clock_output_pin, periph.waveform_out_b, periph.transmit,
			periph.second_pwm_output}, latch_q[4], gp_en[4]);
		{drive_en_d[4], drive_d[4]} = r;
		// Pin 5: wave A, first PWM, latch.
		r = pick({3'h0, periph.waveform_out_a_en && steer_q[BIT_WAVE_A],
			periph.first_pwm_output_en && steer_q[BIT_FIRST_PWM]},
			{3'h0, periph.waveform_out_a, periph.first_pwm_output}, latch_q[5], gp_en[5]);
		{drive_en_d[5], drive_d[5]} = r;
	end

	// Open-drain pins release the wire instead of driving high.
	always_ff @(posedge clk) begin
		if (reset) begin
			pad <= '0;
		end else begin
			pad.drive <= drive_d;
			pad.drive_en <= drive_en_d & ~(open_drain_q[5:0] & drive_d);
			pad.open_drain <= open_drain_q[5:0];
			pad.slew_limit <= slew_q[5:0];
			pad.schmitt <= thresh_q[5:0];
		end
	end

endmodule
`default_nettype wire

// ### spps_pins_model.sv
// Purpose: Pin model standing outside the six-pin port.
// Assumes: Pads are registered outputs of the port.
// Notes:   A released pin shows the level the bench puts on it.
`default_nettype none
module spps_pins_model
	import spps_pkg::*;
(
	input  wire spps_pkg::spps_pad_s pad,
	input  wire logic [5:0]          ext_level,
	input  wire logic [5:0]          schmitt_skew,
	output var  logic [5:0]          pin_in,
	output var  logic [5:0]          pin_schmitt_in
);
	timeunit 1ns;
	timeprecision 1ps;
	always_comb begin
		pin_in = (pad.drive_en & pad.drive) | (~pad.drive_en & ext_level);
		pin_schmitt_in = pin_in ^ schmitt_skew;
	end
endmodule
`default_nettype wire

// ### spps_port_asserts.sv
// Purpose: Port-level assertions for the six-pin port.
// Assumes: One clock, synchronous active high reset.
// Notes:   Attached to the port by the bind below.
`default_nettype none
module spps_port_chk
	import spps_pkg::*;
(
	input wire logic                   clk,
	input wire logic                   reset,
	input wire logic                   s_axi_arvalid,
	input wire logic                   s_axi_arready,
	input wire logic                   s_axi_rvalid,
	input wire logic                   s_axi_bvalid,
	input wire logic                   s_axi_bready,
	input wire spps_pkg::spps_periph_s periph,
	input wire spps_pkg::spps_pad_s    pad,
	input wire spps_pkg::spps_inputs_s inputs
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	pin3_input_a: assert property (pad.drive_en[3] == 1'b0)
		else $error("pin 3 driven");
	pin0_program_a: assert property (periph.programming_data_en
		|=> pad.drive[0] == $past(periph.programming_data)) else $error("pin 0 priority wrong");
	pin2_fault_a: assert property (periph.waveform_fault_en && !periph.waveform_out_a_en
		|=> pad.drive[2] == $past(periph.waveform_fault)) else $error("pin 2 priority wrong");
	pin4_clock_a: assert property (periph.clock_output_en
		|=> pad.drive[4] == $past(periph.clock_output_pin)) else $error("pin 4 priority wrong");
	open_drain_a: assert property ((pad.open_drain & pad.drive & pad.drive_en) == 6'h00)
		else $error("open drain pin sources current");
	analog_pins_a: assert property (inputs.analog_active[5] == 1'b0 && inputs.analog_active[3] == 1'b0)
		else $error("analog active on digital-only pin");
	reset_state_a: assert property ($past(reset) |-> pad == '0 && inputs == '0)
		else $error("pad not cleared by reset");
	write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
endmodule
bind spps_port spps_port_chk u_chk (.clk(clk), .reset(reset), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .periph(periph), .pad(pad), .inputs(inputs));
`default_nettype wire

// ### test_six_pin_port_with_pin_steering.sv
// Purpose: Self-checking bench for the six-pin port with pin steering.
// Assumes: AXI4-Lite master tasks; pins come from spps_pins_model.
// Notes:   Register table loop first, then steering, priority and pin reads.
`default_nettype none
`define CHECK(w, e, g) \
	begin \
		comparisons++; \
		if ((g) !== (e)) begin \
			fails++; \
			$display("[ERR] %s expected %h seen %h", w, e, g); \
		end \
	end
module test_six_pin_port_with_pin_steering
	import spps_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [7:0] a; logic [7:0] r; logic [7:0] w; logic [7:0] e;} spps_row_s;
	localparam spps_row_s ROWS [7] = '{'{ADDR_STEER, 8'h00, 8'hFF, 8'hEF}, '{ADDR_DIR, 8'h3F, 8'hC0, 8'h08},
		'{ADDR_LATCH, 8'h00, 8'hFF, 8'h37}, '{ADDR_ANALOG, 8'h17, 8'hE8, 8'h00},
		'{ADDR_OPEN_DRAIN, 8'h00, 8'hFF, 8'h37}, '{ADDR_SLEW, 8'h37, 8'h00, 8'h00},
		'{ADDR_THRESH, 8'h00, 8'hFF, 8'h3F}};
	logic         clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0]   s_axi_awaddr, s_axi_araddr;
	logic [31:0]  s_axi_wdata, s_axi_rdata, rdat;
	logic [3:0]   s_axi_wstrb;
	logic [1:0]   s_axi_bresp, s_axi_rresp, bres, rres;
	logic [5:0]   pin_in, pin_schmitt_in, ext_level, schmitt_skew;
	logic [20:0]  pv;
	spps_periph_s periph;
	spps_pad_s    pad;
	spps_inputs_s inputs;
	int           fails = 0;
	int           comparisons = 0;
	int           lo_step [5] = '{14, 12, 6, 2, 4};
	int           bit_step [5] = '{6, 5, 2, 1, 0};
	int           clr_pin [5] = '{2, 0, 0, 0, 1};
	int           set_pin [5] = '{5, 4, 4, 4, 5};
	int           lo_pin2 [4] = '{14, 10, 8, 0};
	int           lo_pin4 [4] = '{16, 12, 6, 2};
	spps_port DUT (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_schmitt_in,
		.periph, .pad, .inputs);
	spps_pins_model u_pins (.pad, .ext_level, .schmitt_skew, .pin_in, .pin_schmitt_in);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic summarize();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 50);
		bres = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 50);
		rdat = s_axi_rdata;
		rres = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic rdchk(input string w, input logic [7:0] a, input logic [7:0] e);
		rd(a);
		`CHECK(w, {24'h00_0000, e}, rdat)
	endtask
	initial begin
		{reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'b10_0000;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0000, 32'h0000_0000, 4'hF};
		{periph, ext_level, schmitt_skew} = '0;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			rdchk("reset value", ROWS[i].a, ROWS[i].r);
			wr(ROWS[i].a, ROWS[i].w);
			rdchk("read back", ROWS[i].a, ROWS[i].e);
		end
		`CHECK("open drain release", 6'h00, pad.drive_en)
		`CHECK("threshold mirror", 6'h3F, pad.schmitt)
		`CHECK("open drain mirror", 6'h37, pad.open_drain)
		wr(ADDR_OPEN_DRAIN, 8'h00);
		wr(ADDR_SLEW, 8'h05);
		`CHECK("mapped write", RESP_OKAY, bres)
		@(negedge clk);
		`CHECK("push pull drive", 6'h37, pad.drive_en)
		`CHECK("slew mirror", 6'h05, pad.slew_limit)
		wr(8'h20, 8'hFF);
		`CHECK("unmapped write", RESP_SLVERR, bres)
		rd(8'h20);
		`CHECK("unmapped read", {RESP_SLVERR, 32'h0000_0000}, {rres, rdat})
		wr(ADDR_LATCH, 8'h00);
		wr(ADDR_THRESH, 8'h00);
		for (int f = 0; f < 5; f++) begin
			for (int s = 0; s < 2; s++) begin
				@(posedge clk);
				periph <= spps_periph_s'(21'h3 << lo_step[f]);
				wr(ADDR_STEER, 8'(s << bit_step[f]));
				@(negedge clk);
				`CHECK("steered pins", {6'h37, 6'(1 << (s ? set_pin[f] : clr_pin[f]))}, {pad.drive_en, pad.drive & 6'h37})
			end
		end
		@(posedge clk);
		periph <= '0;
		ext_level <= 6'h28;
		wr(ADDR_DIR, 8'h3F);
		for (int s = 0; s < 2; s++) begin
			wr(ADDR_STEER, s ? 8'h88 : 8'h00);
			@(negedge clk);
			`CHECK("receive and gate", {2{1'(s)}}, {inputs.serial_receive_or_sync_data, inputs.timer_gate_input})
		end
		rdchk("direction kept", ADDR_DIR, 8'h3F);
		wr(ADDR_STEER, 8'h26);
		wr(ADDR_DIR, 8'h08);
		wr(ADDR_LATCH, 8'h14);
		for (int k = 0; k < 5; k++) begin
			pv = 21'h18_0000;
			for (int j = k; j < 4; j++) pv = pv | (21'(j % 2 ? 2 : 3) << lo_pin2[j]) | (21'(j % 2 ? 2 : 3) << lo_pin4[j]);
			@(posedge clk);
			periph <= spps_periph_s'(pv);
			@(posedge clk);
			@(negedge clk);
			`CHECK("priority pins", {1'b1, {2{1'(k % 2 == 0)}}}, {pad.drive[0], pad.drive[2], pad.drive[4]})
		end
		@(posedge clk);
		periph <= '0;
		ext_level <= 6'h3F;
		schmitt_skew <= 6'h01;
		wr(ADDR_DIR, 8'h3F);
		wr(ADDR_ANALOG, 8'h17);
		rdchk("analog masked read", ADDR_LEVELS, 8'h28);
		`CHECK("analog active", 6'h17, inputs.analog_active)
		wr(ADDR_ANALOG, 8'h00);
		rdchk("ttl read", ADDR_LEVELS, 8'h3F);
		wr(ADDR_THRESH, 8'h01);
		rdchk("schmitt read", ADDR_LEVELS, 8'h3E);
		wr(ADDR_THRESH, 8'h00);
		wr(ADDR_LEVELS, 8'h15);
		rdchk("latch after port write", ADDR_LATCH, 8'h15);
		rdchk("pins not latch", ADDR_LEVELS, 8'h3F);
		wr(ADDR_DIR, 8'h00);
		rdchk("driven pins", ADDR_LEVELS, 8'h1D);
		wr(ADDR_ANALOG, 8'h17);
		rdchk("analog with outputs", ADDR_LEVELS, 8'h08);
		`CHECK("analog drive", 6'h37, pad.drive_en)
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		rdchk("second reset", ADDR_DIR, 8'h3F);
		summarize();
	end
	initial begin
		repeat (20_000) @(posedge clk);
		fails++;
		summarize();
	end
endmodule
`default_nettype wire
